// File: src/t16wc_codec.sv
// top of the transparent 16-bit fieldbus command and state word codec
// Operation
// - command word at object 2051h is stored exactly as written, no remapping.
// - command bit 0 set requests a stop with override or configured method.
// - bit 1 set requests start; bit 2 set requests reversed rotation.
// - fault clear pulses only on a 0 to 1 change of bit 4.
// - with fieldbus site choice, bit 5 picks second site, else first.
// - with fieldbus run permit, bit 6 set withdraws permit, clear grants.
// - bit 7 normal ramp, bit 8 urgent ramp, bit 9 freewheel stop.
// - with bits 7 to 9 all clear, use the configured stop method.
// - bit 11 set forces ramp generator output to zero.
// - bit 12 set freezes the ramp generator output.
// - bit 13 set forces the ramp generator input to zero.
// - the 16-bit state word is readable at object 2054h.
// - state bit 0 shows the drive accepts a start command.
// - state bit 1 shows the external run permit is active.
// - state bit 3 shows the drive is modulating.
// - state bit 4 shows the drive is at zero speed.
// - state bit 7 shows the setpoint has been reached.
// - state bit 8 shows drive operation is being limited.
// - state bit 9 shows a supervised value is above its limit.
// - bit 12 shows keypad local control, bit 13 fieldbus local control.
// - state bit 14 shows the second external site is active.
// - state bit 15 shows the drive is faulted.
`timescale 1ns/1ps
`default_nettype none
module t16wc_codec (
  input wire logic sys_clk,
  input wire logic rstn,
  // object access from the fieldbus side
  input wire logic obj_wr_en,
  input wire logic obj_rd_en,
  input wire logic [15:0] obj_index,
  input wire logic [15:0] obj_wdata,
  output logic [15:0] obj_rdata,
  output logic obj_ack,
  output logic obj_err,
  // configuration from the drive
  input wire t16wc_pkg::t16wc_stop_t cfg_stop_mode,
  input wire logic cfg_site_from_fieldbus,
  input wire logic cfg_run_permit_from_fieldbus,
  // drive state
  input wire logic drv_ready,
  input wire logic drv_run_permit,
  input wire logic drv_modulating,
  input wire logic drv_zero_speed,
  input wire logic drv_at_target,
  input wire logic drv_limited,
  input wire logic drv_supervision,
  input wire logic drv_panel_local,
  input wire logic drv_fieldbus_local,
  input wire logic drv_second_site,
  input wire logic drv_fault,
  // drive commands
  output logic stop_req,
  output t16wc_pkg::t16wc_stop_t stop_method,
  output logic start_req,
  output logic reverse_req,
  output logic fault_clear,
  output logic site_select_valid,
  output logic second_external_site,
  output logic run_permit_fb,
  output logic ramp_out_zero,
  output logic ramp_hold,
  output logic ramp_in_zero,
  output logic [15:0] state_word
);
  import t16wc_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic idx_hit(input logic [15:0] index, input logic [15:0] target);
    idx_hit = (index == target);
  endfunction

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    t16wc_fsm_t fsm;
    logic [15:0] cmd_word;
    logic [15:0] state_word;
    logic [15:0] rdata;
    logic ack;
    logic err;
    logic fault_clear;
    logic stop_req;
    t16wc_stop_t stop_method;
    logic start_req;
    logic reverse_req;
    logic site_valid;
    logic site_second;
    logic run_permit;
    logic ramp_out_zero;
    logic ramp_hold;
    logic ramp_in_zero;
  } t16wc_regs_t;

  localparam t16wc_regs_t T16WC_REGS_RESET = '{
    fsm: T16WC_FSM_RESET,
    cmd_word: T16WC_CMD_RESET,
    state_word: T16WC_STATE_RESET,
    rdata: T16WC_RDATA_IDLE,
    ack: 1'b0,
    err: 1'b0,
    fault_clear: 1'b0,
    stop_req: 1'b0,
    stop_method: T16WC_STOP_NORMAL_RAMP,
    start_req: 1'b0,
    reverse_req: 1'b0,
    site_valid: 1'b0,
    site_second: 1'b0,
    run_permit: 1'b1,
    ramp_out_zero: 1'b0,
    ramp_hold: 1'b0,
    ramp_in_zero: 1'b0
  };

  t16wc_regs_t regs_q;
  t16wc_regs_t regs_d;

  // ****************************************
  // combinational helpers
  // ****************************************
  logic hit_cmd;
  logic hit_state;
  logic wr_take;
  logic rd_take;
  logic [15:0] cmd_next;
  logic [15:0] state_now;
  t16wc_stop_t method_now;

  assign hit_cmd = idx_hit(obj_index, T16WC_IDX_CMD);
  assign hit_state = idx_hit(obj_index, T16WC_IDX_STATE);
  // a write wins over a read arriving in the same cycle
  assign wr_take = (regs_q.fsm == T16WC_ST_IDLE) && obj_wr_en;
  assign rd_take = (regs_q.fsm == T16WC_ST_IDLE) && obj_rd_en && !obj_wr_en;
  assign cmd_next = (wr_take && hit_cmd) ? obj_wdata : regs_q.cmd_word;

  // ****************************************
  // sub-blocks
  // ****************************************
  t16wc_stop_resolve u_stop_resolve (
    .normal_ramp_stop_override(cmd_next[T16WC_CB_NORMAL_RAMP]),
    .urgent_ramp_stop_override(cmd_next[T16WC_CB_URGENT_RAMP]),
    .freewheel_stop_override(cmd_next[T16WC_CB_FREEWHEEL]),
    .cfg_stop_mode(cfg_stop_mode),
    .stop_method(method_now)
  );

  t16wc_state_pack u_state_pack (
    .ready(drv_ready),
    .run_permit_active_flag(drv_run_permit),
    .modulating_flag(drv_modulating),
    .zero_speed(drv_zero_speed),
    .target_reached_flag(drv_at_target),
    .limited(drv_limited),
    .supervision(drv_supervision),
    .panel_local(drv_panel_local),
    .fieldbus_local(drv_fieldbus_local),
    .second_site_active_flag(drv_second_site),
    .fault(drv_fault),
    .state_word(state_now)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    regs_d = regs_q;
    regs_d.ack = 1'b0;
    regs_d.err = 1'b0;
    regs_d.fault_clear = 1'b0;

    // object access handshake
    unique case (regs_q.fsm)
      T16WC_ST_IDLE: begin
        if (wr_take) begin
          regs_d.fsm = T16WC_ST_ANSWER;
          regs_d.rdata = T16WC_RDATA_IDLE;
          if (hit_cmd) begin
            regs_d.ack = 1'b1;
          end else begin
            // state word is read only, other indices are unmapped
            regs_d.err = 1'b1;
          end
        end else if (rd_take) begin
          regs_d.fsm = T16WC_ST_ANSWER;
          if (hit_state) begin
            regs_d.rdata = state_now;
            regs_d.ack = 1'b1;
          end else begin
            // command word is write only, other indices are unmapped
            regs_d.rdata = T16WC_RDATA_IDLE;
            regs_d.err = 1'b1;
          end
        end
      end
      T16WC_ST_ANSWER: begin
        regs_d.fsm = T16WC_ST_IDLE;
      end
      default: begin
        regs_d.fsm = T16WC_ST_IDLE;
      end
    endcase

    // command word store
    regs_d.cmd_word = cmd_next;

    // fault clear on a rising bit 4 while a fault is present
    if (!regs_q.cmd_word[T16WC_CB_FAULT_CLR] && cmd_next[T16WC_CB_FAULT_CLR] && drv_fault) begin
      regs_d.fault_clear = 1'b1;
    end

    // run commands
    regs_d.stop_req = cmd_next[T16WC_CB_STOP];
    regs_d.stop_method = method_now;
    regs_d.start_req = cmd_next[T16WC_CB_START];
    regs_d.reverse_req = cmd_next[T16WC_CB_REVERSE];

    // control site selection
    regs_d.site_valid = cfg_site_from_fieldbus;
    regs_d.site_second = cfg_site_from_fieldbus && cmd_next[T16WC_CB_SITE];

    // run permit, held granted while the fieldbus does not own it
    regs_d.run_permit = !(cfg_run_permit_from_fieldbus && cmd_next[T16WC_CB_RUN_DISABLE]);

    // ramp generator control
    regs_d.ramp_out_zero = cmd_next[T16WC_CB_RAMP_OUT_ZERO];
    regs_d.ramp_hold = cmd_next[T16WC_CB_RAMP_HOLD];
    regs_d.ramp_in_zero = cmd_next[T16WC_CB_RAMP_IN_ZERO];

    // bits 3, 10, 14 and 15 are stored but drive nothing

    // live state word
    regs_d.state_word = state_now;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      regs_q <= T16WC_REGS_RESET;
    end else begin
      regs_q <= regs_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign obj_rdata = regs_q.rdata;
  assign obj_ack = regs_q.ack;
  assign obj_err = regs_q.err;
  assign stop_req = regs_q.stop_req;
  assign stop_method = regs_q.stop_method;
  assign start_req = regs_q.start_req;
  assign reverse_req = regs_q.reverse_req;
  assign fault_clear = regs_q.fault_clear;
  assign site_select_valid = regs_q.site_valid;
  assign second_external_site = regs_q.site_second;
  assign run_permit_fb = regs_q.run_permit;
  assign ramp_out_zero = regs_q.ramp_out_zero;
  assign ramp_hold = regs_q.ramp_hold;
  assign ramp_in_zero = regs_q.ramp_in_zero;
  assign state_word = regs_q.state_word;

endmodule // t16wc_codec
`default_nettype wire

// File: inc/t16wc_pkg.sv
// constants and types shared by the transparent 16-bit word codec
package t16wc_pkg;

  // ****************************************
  // object indices
  // ****************************************
  localparam logic [15:0] T16WC_IDX_CMD = 16'h2051;
  localparam logic [15:0] T16WC_IDX_STATE = 16'h2054;

  // ****************************************
  // command word bit positions
  // ****************************************
  localparam int T16WC_CB_STOP = 0;
  localparam int T16WC_CB_START = 1;
  localparam int T16WC_CB_REVERSE = 2;
  localparam int T16WC_CB_FAULT_CLR = 4;
  localparam int T16WC_CB_SITE = 5;
  localparam int T16WC_CB_RUN_DISABLE = 6;
  localparam int T16WC_CB_NORMAL_RAMP = 7;
  localparam int T16WC_CB_URGENT_RAMP = 8;
  localparam int T16WC_CB_FREEWHEEL = 9;
  localparam int T16WC_CB_RAMP_OUT_ZERO = 11;
  localparam int T16WC_CB_RAMP_HOLD = 12;
  localparam int T16WC_CB_RAMP_IN_ZERO = 13;

  // ****************************************
  // state word bit positions
  // ****************************************
  localparam int T16WC_SB_READY = 0;
  localparam int T16WC_SB_RUN_PERMIT = 1;
  localparam int T16WC_SB_MODULATING = 3;
  localparam int T16WC_SB_ZERO_SPEED = 4;
  localparam int T16WC_SB_TARGET = 7;
  localparam int T16WC_SB_LIMIT = 8;
  localparam int T16WC_SB_SUPERVISION = 9;
  localparam int T16WC_SB_PANEL_LOCAL = 12;
  localparam int T16WC_SB_FIELDBUS_LOCAL = 13;
  localparam int T16WC_SB_SECOND_SITE = 14;
  localparam int T16WC_SB_FAULT = 15;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] T16WC_CMD_RESET = 16'h0000;
  localparam logic [15:0] T16WC_STATE_RESET = 16'h0000;
  localparam logic [15:0] T16WC_RDATA_IDLE = 16'h0000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    T16WC_STOP_NORMAL_RAMP = 2'h0,
    T16WC_STOP_URGENT_RAMP = 2'h1,
    T16WC_STOP_FREEWHEEL = 2'h2
  } t16wc_stop_t;

  typedef enum logic [1:0] {
    T16WC_ST_IDLE = 2'h1,
    T16WC_ST_ANSWER = 2'h2
  } t16wc_fsm_t;

  localparam t16wc_fsm_t T16WC_FSM_RESET = T16WC_ST_IDLE;

endpackage

// File: src/t16wc_stop_resolve.sv
// stop method selection from override bits and configuration
`timescale 1ns/1ps
`default_nettype none
module t16wc_stop_resolve (
  input wire logic normal_ramp_stop_override,
  input wire logic urgent_ramp_stop_override,
  input wire logic freewheel_stop_override,
  input wire t16wc_pkg::t16wc_stop_t cfg_stop_mode,
  output t16wc_pkg::t16wc_stop_t stop_method
);
  import t16wc_pkg::*;

  // ****************************************
  // resolve
  // ****************************************
  // strongest override wins when several are set
  always_comb begin
    if (freewheel_stop_override) begin
      stop_method = T16WC_STOP_FREEWHEEL;
    end else if (urgent_ramp_stop_override) begin
      stop_method = T16WC_STOP_URGENT_RAMP;
    end else if (normal_ramp_stop_override) begin
      stop_method = T16WC_STOP_NORMAL_RAMP;
    end else begin
      stop_method = cfg_stop_mode;
    end
  end

endmodule // t16wc_stop_resolve
`default_nettype wire

// File: src/t16wc_state_pack.sv
// assembly of the 16-bit state word from drive state
`timescale 1ns/1ps
`default_nettype none
module t16wc_state_pack (
  input wire logic ready,
  input wire logic run_permit_active_flag,
  input wire logic modulating_flag,
  input wire logic zero_speed,
  input wire logic target_reached_flag,
  input wire logic limited,
  input wire logic supervision,
  input wire logic panel_local,
  input wire logic fieldbus_local,
  input wire logic second_site_active_flag,
  input wire logic fault,
  output logic [15:0] state_word
);
  import t16wc_pkg::*;

  // ****************************************
  // pack
  // ****************************************
  always_comb begin
    state_word = 16'h0000;
    state_word[T16WC_SB_READY] = ready;
    state_word[T16WC_SB_RUN_PERMIT] = run_permit_active_flag;
    state_word[T16WC_SB_MODULATING] = modulating_flag;
    state_word[T16WC_SB_ZERO_SPEED] = zero_speed;
    state_word[T16WC_SB_TARGET] = target_reached_flag;
    state_word[T16WC_SB_LIMIT] = limited;
    state_word[T16WC_SB_SUPERVISION] = supervision;
    state_word[T16WC_SB_PANEL_LOCAL] = panel_local;
    state_word[T16WC_SB_FIELDBUS_LOCAL] = fieldbus_local;
    state_word[T16WC_SB_SECOND_SITE] = second_site_active_flag;
    state_word[T16WC_SB_FAULT] = fault;
  end

endmodule // t16wc_state_pack
`default_nettype wire

// File: verif/t16wc_codec_props.sv
// assertion checker bound to the word codec top
`timescale 1ns/1ps
`default_nettype none
module t16wc_codec_props (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic obj_wr_en,
  input wire logic obj_rd_en,
  input wire logic [15:0] obj_index,
  input wire logic [15:0] obj_wdata,
  input wire logic [15:0] obj_rdata,
  input wire logic obj_ack,
  input wire logic obj_err,
  input wire t16wc_pkg::t16wc_stop_t cfg_stop_mode,
  input wire logic cfg_site_from_fieldbus,
  input wire logic cfg_run_permit_from_fieldbus,
  input wire logic drv_ready,
  input wire logic drv_run_permit,
  input wire logic drv_modulating,
  input wire logic drv_zero_speed,
  input wire logic drv_at_target,
  input wire logic drv_limited,
  input wire logic drv_supervision,
  input wire logic drv_panel_local,
  input wire logic drv_fieldbus_local,
  input wire logic drv_second_site,
  input wire logic drv_fault,
  input wire logic stop_req,
  input wire t16wc_pkg::t16wc_stop_t stop_method,
  input wire logic start_req,
  input wire logic reverse_req,
  input wire logic fault_clear,
  input wire logic site_select_valid,
  input wire logic second_external_site,
  input wire logic run_permit_fb,
  input wire logic ramp_out_zero,
  input wire logic ramp_hold,
  input wire logic ramp_in_zero,
  input wire logic [15:0] state_word
);
  import t16wc_pkg::*;
  logic busy;
  logic tk_wr;
  logic [15:0] cmd_q;
  logic [15:0] sw_exp;
  assign busy = obj_ack | obj_err;
  assign tk_wr = obj_wr_en & ~busy & (obj_index == T16WC_IDX_CMD);
  assign sw_exp = {drv_fault, drv_second_site, drv_fieldbus_local, drv_panel_local, 2'h0, drv_supervision,
    drv_limited, drv_at_target, 2'h0, drv_zero_speed, drv_modulating, 1'h0, drv_run_permit, drv_ready};
  // shadow of the stored command word
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) cmd_q <= 16'h0000;
    else if (tk_wr) cmd_q <= obj_wdata;
  end
  function automatic t16wc_stop_t f_stop(input logic [2:0] ov, input t16wc_stop_t c);
    if (ov[2]) return T16WC_STOP_FREEWHEEL;
    if (ov[1]) return T16WC_STOP_URGENT_RAMP;
    if (ov[0]) return T16WC_STOP_NORMAL_RAMP;
    return c;
  endfunction
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_rd;
    obj_rd_en & ~obj_wr_en & ~busy & (obj_index == T16WC_IDX_STATE);
  endsequence
  sequence s_bad;
    ~busy & (obj_wr_en ? obj_index != T16WC_IDX_CMD : obj_rd_en & (obj_index != T16WC_IDX_STATE));
  endsequence
  sequence s_ack1;
    obj_ack & ~obj_err ##1 ~busy;
  endsequence
  sequence s_err1;
    obj_err & ~obj_ack & (obj_rdata == 16'h0000) ##1 ~busy;
  endsequence
  AST_WR_ACK: assert property (tk_wr |=> s_ack1)
    else $error("command write not answered once");
  AST_CMD_OUT: assert property (tk_wr |=>
    {ramp_in_zero, ramp_hold, ramp_out_zero, reverse_req, start_req, stop_req} ==
    {$past(obj_wdata[13:11]), $past(obj_wdata[2:0])})
    else $error("command outputs differ from written word");
  AST_RD_STATE: assert property (s_rd |=> s_ack1 and (obj_rdata == state_word))
    else $error("state read answer wrong");
  AST_BAD: assert property (s_bad |=> s_err1)
    else $error("bad request not refused");
  AST_STATE: assert property ($past(rstn) |->
    state_word == $past(sw_exp))
    else $error("state word does not follow drive state");
  AST_FCLR: assert property ($past(rstn) |->
    fault_clear == $past(tk_wr & obj_wdata[4] & ~cmd_q[4] & drv_fault))
    else $error("fault clear pulse wrong");
  AST_SITE: assert property ($past(rstn) |-> {second_external_site, site_select_valid} ==
    {$past(cfg_site_from_fieldbus) & cmd_q[5], $past(cfg_site_from_fieldbus)})
    else $error("site selection wrong");
  AST_PERMIT: assert property ($past(rstn) |->
    run_permit_fb == ~($past(cfg_run_permit_from_fieldbus) & cmd_q[6]))
    else $error("run permit wrong");
  AST_STOP: assert property ($past(rstn) |-> stop_method == f_stop(cmd_q[9:7], $past(cfg_stop_mode)))
    else $error("stop method wrong");
endmodule // t16wc_codec_props
`default_nettype wire

// File: verif/t16wc_fb_master.sv
// fieldbus master model issuing object requests
`timescale 1ns/1ps
`default_nettype none
module t16wc_fb_master (
  input wire logic sys_clk,
  output logic obj_wr_en,
  output logic obj_rd_en,
  output logic [15:0] obj_index,
  output logic [15:0] obj_wdata,
  input wire logic [15:0] obj_rdata,
  input wire logic obj_ack,
  input wire logic obj_err
);
  initial begin
    obj_wr_en = 1'b0;
    obj_rd_en = 1'b0;
    obj_index = 16'h0000;
    obj_wdata = 16'h0000;
  end
  // request held through the answer edge, then released
  task automatic req(input logic wr, input logic rd, input logic [15:0] idx, input logic [15:0] d,
    output logic ack, output logic err, output logic [15:0] rdat);
    @(negedge sys_clk);
    obj_wr_en = wr;
    obj_rd_en = rd;
    obj_index = idx;
    obj_wdata = d;
    @(negedge sys_clk);
    ack = obj_ack;
    err = obj_err;
    rdat = obj_rdata;
    @(negedge sys_clk);
    obj_wr_en = 1'b0;
    obj_rd_en = 1'b0;
    // released lines carry the inverse so stale values never match
    obj_index = ~idx;
    obj_wdata = ~d;
  endtask
endmodule // t16wc_fb_master
`default_nettype wire

// File: verif/t16wc_codec_tb.sv
// self-checking bench of the word codec
`timescale 1ns/1ps
`default_nettype none
module t16wc_codec_tb;
  import t16wc_pkg::*;
  logic sys_clk, rstn, obj_wr_en, obj_rd_en, obj_ack, obj_err, cfg_site_from_fieldbus, cfg_run_permit_from_fieldbus;
  logic [15:0] obj_index, obj_wdata, obj_rdata, state_word;
  logic drv_ready, drv_run_permit, drv_modulating, drv_zero_speed, drv_at_target, drv_limited, drv_supervision;
  logic drv_panel_local, drv_fieldbus_local, drv_second_site, drv_fault, stop_req, start_req, reverse_req;
  logic fault_clear, site_select_valid, second_external_site, run_permit_fb, ramp_out_zero, ramp_hold, ramp_in_zero;
  t16wc_stop_t cfg_stop_mode, stop_method;
  int fail_count = 0, n_checks = 0, fc_cnt = 0, cyc = 0;
  t16wc_codec i_dut (.sys_clk, .rstn, .obj_wr_en, .obj_rd_en, .obj_index, .obj_wdata, .obj_rdata, .obj_ack,
    .obj_err, .cfg_stop_mode, .cfg_site_from_fieldbus, .cfg_run_permit_from_fieldbus, .drv_ready, .drv_run_permit,
    .drv_modulating, .drv_zero_speed, .drv_at_target, .drv_limited, .drv_supervision, .drv_panel_local,
    .drv_fieldbus_local, .drv_second_site, .drv_fault, .stop_req, .stop_method, .start_req, .reverse_req,
    .fault_clear, .site_select_valid, .second_external_site, .run_permit_fb, .ramp_out_zero, .ramp_hold,
    .ramp_in_zero, .state_word);
  t16wc_fb_master i_mst (.sys_clk, .obj_wr_en, .obj_rd_en, .obj_index, .obj_wdata, .obj_rdata, .obj_ack, .obj_err);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (fault_clear === 1'b1) fc_cnt++;
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic set_drv(input logic [10:0] p);
    {drv_fault, drv_second_site, drv_fieldbus_local, drv_panel_local, drv_supervision, drv_limited,
      drv_at_target, drv_zero_speed, drv_modulating, drv_run_permit, drv_ready} = p;
  endtask
  task automatic wr(input logic [15:0] d);
    logic a, e;
    logic [15:0] r;
    i_mst.req(1'b1, 1'b0, T16WC_IDX_CMD, d, a, e, r);
    chk({a, e}, 2'b10);
  endtask
  task automatic t_cmd();
    logic [15:0] w [3] = '{16'h3807, 16'hc408, 16'h1802};
    foreach (w[i]) begin
      wr(w[i]);
      chk({ramp_in_zero, ramp_hold, ramp_out_zero, reverse_req, start_req, stop_req},
        {w[i][13:11], w[i][2:0]});
    end
  endtask
  task automatic t_stop();
    logic [15:0] w [5] = '{16'h0081, 16'h0101, 16'h0201, 16'h0381, 16'h0001};
    t16wc_stop_t e [5] = '{T16WC_STOP_NORMAL_RAMP, T16WC_STOP_URGENT_RAMP, T16WC_STOP_FREEWHEEL,
      T16WC_STOP_FREEWHEEL, T16WC_STOP_URGENT_RAMP};
    cfg_stop_mode = T16WC_STOP_URGENT_RAMP;
    foreach (w[i]) begin
      wr(w[i]);
      chk(stop_method, e[i]);
    end
  endtask
  task automatic t_fault();
    int n;
    n = fc_cnt;
    drv_fault = 1'b1;
    wr(16'h0010);
    wr(16'h0010);
    chk(16'(fc_cnt - n), 16'h0001);
    wr(16'h0000);
    drv_fault = 1'b0;
    wr(16'h0010);
    chk(16'(fc_cnt - n), 16'h0001);
    drv_fault = 1'b1;
    wr(16'h0000);
    wr(16'h0010);
    chk(16'(fc_cnt - n), 16'h0002);
  endtask
  task automatic t_site();
    cfg_site_from_fieldbus = 1'b1;
    cfg_run_permit_from_fieldbus = 1'b1;
    wr(16'h0060);
    chk({second_external_site, site_select_valid, run_permit_fb}, 3'b110);
    wr(16'h0000);
    chk({second_external_site, site_select_valid, run_permit_fb}, 3'b011);
    cfg_site_from_fieldbus = 1'b0;
    cfg_run_permit_from_fieldbus = 1'b0;
    wr(16'h0060);
    chk({second_external_site, site_select_valid, run_permit_fb}, 3'b001);
  endtask
  task automatic t_state();
    logic [10:0] p [3] = '{11'h7ff, 11'h555, 11'h2aa};
    logic a, e;
    logic [15:0] r, x;
    foreach (p[i]) begin
      set_drv(p[i]);
      x = {p[i][10:7], 2'h0, p[i][6:4], 2'h0, p[i][3:2], 1'h0, p[i][1:0]};
      i_mst.req(1'b0, 1'b1, T16WC_IDX_STATE, 16'h0000, a, e, r);
      chk({a, e}, 2'b10);
      chk(r, x);
      chk(state_word, x);
    end
  endtask
  task automatic t_err();
    logic [1:0] m [4] = '{2'b01, 2'b10, 2'b01, 2'b11};
    logic [15:0] x [4] = '{T16WC_IDX_CMD, T16WC_IDX_STATE, 16'h2055, T16WC_IDX_CMD};
    logic [1:0] q [4] = '{2'b01, 2'b01, 2'b01, 2'b10};
    logic a, e;
    logic [15:0] r;
    foreach (m[i]) begin
      i_mst.req(m[i][1], m[i][0], x[i], 16'h0004, a, e, r);
      chk({a, e}, q[i]);
      if (i == 1) chk(reverse_req, 1'b0);
    end
    chk(reverse_req, 1'b1);
  endtask
  task automatic t_rst2();
    cfg_run_permit_from_fieldbus = 1'b1;
    wr(16'h0043);
    rstn = 1'b0;
    @(negedge sys_clk);
    chk({run_permit_fb, stop_req, start_req}, 3'b100);
    rstn = 1'b1;
    wr(16'h0001);
    chk({run_permit_fb, stop_req}, 2'b11);
  endtask
  initial begin
    rstn = 1'b0;
    set_drv(11'h000);
    cfg_stop_mode = T16WC_STOP_NORMAL_RAMP;
    cfg_site_from_fieldbus = 1'b0;
    cfg_run_permit_from_fieldbus = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk(state_word, 16'h0000);
    chk({run_permit_fb, stop_req}, 2'b10);
    rstn = 1'b1;
    t_cmd();
    t_stop();
    t_fault();
    t_site();
    t_state();
    t_err();
    t_rst2();
    end_sim();
  end
endmodule // t16wc_codec_tb
bind t16wc_codec t16wc_codec_props i_props (.sys_clk, .rstn, .obj_wr_en, .obj_rd_en, .obj_index, .obj_wdata,
  .obj_rdata, .obj_ack, .obj_err, .cfg_stop_mode, .cfg_site_from_fieldbus, .cfg_run_permit_from_fieldbus,
  .drv_ready, .drv_run_permit, .drv_modulating, .drv_zero_speed, .drv_at_target, .drv_limited, .drv_supervision,
  .drv_panel_local, .drv_fieldbus_local, .drv_second_site, .drv_fault, .stop_req, .stop_method, .start_req,
  .reverse_req, .fault_clear, .site_select_valid, .second_external_site, .run_permit_fb, .ramp_out_zero,
  .ramp_hold, .ramp_in_zero, .state_word);
`default_nettype wire
